// [hdl/twi_host_pkg.sv]
// Package for the two-wire host controller: timing, codes, enums and carriers
package twi_host_pkg;
    localparam int CLK_KHZ = 125000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_FAST_KHZ = 400;
    localparam int SCL_HS_KHZ = 3400;
    localparam int T_LOW_FAST_NS = 1300;
    localparam int T_LOW_HS_NS = 160;
    localparam int PER_FAST_CYC = (CLK_KHZ + SCL_FAST_KHZ - 1) / SCL_FAST_KHZ;
    localparam int PER_HS_CYC = (CLK_KHZ + SCL_HS_KHZ - 1) / SCL_HS_KHZ;
    localparam int LOW_FAST_CYC = (T_LOW_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOW_HS_CYC = (T_LOW_HS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HIGH_FAST_CYC = PER_FAST_CYC - LOW_FAST_CYC;
    localparam int HIGH_HS_CYC = PER_HS_CYC - LOW_HS_CYC;
    localparam int CNT_W = 9;
    localparam logic [7:0] ALERT_RESP_BYTE = 8'h19;
    localparam logic [7:0] GCALL_WRITE_BYTE = 8'h00;
    localparam logic [7:0] GCALL_LATCH_CMD = 8'h04;
    localparam logic [7:0] GCALL_RESET_CMD = 8'h06;
    localparam logic [4:0] HS_CODE_PREFIX = 5'h01;
    localparam logic [3:0] DEV_ADDR_BASE = 4'h9;

    typedef enum logic [1:0] {cmd_start, cmd_stop, cmd_bit} eng_cmd_type;
    typedef enum logic [2:0] {op_write, op_read, op_alert, op_gcall_latch, op_gcall_reset} op_type;

    typedef struct packed {
        op_type op;
        logic hs;
        logic [2:0] addr_pins;
        logic [7:0] pointer;
        logic [15:0] wdata;
        logic [1:0] nbytes;
    } req_type;

    typedef struct packed {
        logic [15:0] rdata;
        logic nack;
        logic [6:0] alert_addr;
        logic alert_flag;
    } resp_type;
endpackage

// [hdl/twi_bit_engine.sv]
// Bit-level engine: START, STOP and single bit slots on SCL and SDA
`timescale 1ns/100ps
module twi_bit_engine
    import twi_host_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic cmd_valid,
    input wire eng_cmd_type cmd,
    input wire logic tx_bit,
    input wire logic hs,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic done,
    output logic rx_bit,
    output logic scl_oe_n,
    output logic sda_oe_n
);
    typedef enum {eng_idle, eng_run} eng_state_type;

    eng_state_type st, next_st;
    eng_cmd_type cmd_r, next_cmd;
    logic [1:0] step, next_step;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic tx_r, next_tx, next_done, next_rx, next_scl_oe_n, next_sda_oe_n, load;
    logic scl_meta, scl_sync, sda_meta, sda_sync;
    logic [3:0] plan;
    logic [1:0] last_step;
    logic [9:0] low_run;

    // Plan of a step: {sda pulled low, scl pulled low, wait kind}; wait 0 low, 1 high, 2 one
    function automatic logic [3:0] step_plan(eng_cmd_type c, logic [1:0] s, logic tx,
                                             logic sda_l, logic scl_l);
        logic [3:0] p;
        p = {sda_l, scl_l, 2'h0};
        case (c)
            cmd_start: begin
                case (s)
                    2'h0: p = {1'h0, scl_l, 2'h0};
                    2'h1: p = {1'h0, 1'h0, 2'h1};
                    2'h2: p = {1'h1, 1'h0, 2'h1};
                    default: p = {1'h1, 1'h1, 2'h0};
                endcase
            end
            cmd_stop: begin
                case (s)
                    2'h0: p = {1'h1, 1'h1, 2'h0};
                    2'h1: p = {1'h1, 1'h0, 2'h1};
                    default: p = {1'h0, 1'h0, 2'h0};
                endcase
            end
            default: begin
                case (s)
                    2'h0: p = {~tx, 1'h1, 2'h0};
                    2'h1: p = {sda_l, 1'h0, 2'h1};
                    default: p = {sda_l, 1'h1, 2'h2};
                endcase
            end
        endcase
        return p;
    endfunction

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            scl_meta <= 1'h1;
            scl_sync <= 1'h1;
            sda_meta <= 1'h1;
            sda_sync <= 1'h1;
        end else begin
            scl_meta <= scl_in;
            scl_sync <= scl_meta;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
        end
    end

    assign last_step = (cmd_r == cmd_start) ? 2'h3 : 2'h2;

    always_comb begin
        next_st = st;
        next_cmd = cmd_r;
        next_step = step;
        next_cnt = cnt;
        next_tx = tx_r;
        next_done = 1'h0;
        next_rx = rx_bit;
        next_scl_oe_n = scl_oe_n;
        next_sda_oe_n = sda_oe_n;
        load = 1'h0;
        plan = 4'h0;
        case (st)
            eng_idle: begin
                if (cmd_valid) begin
                    next_st = eng_run;
                    next_cmd = cmd;
                    next_tx = tx_bit;
                    next_step = 2'h0;
                    plan = step_plan(cmd, 2'h0, tx_bit, ~sda_oe_n, ~scl_oe_n);
                    load = 1'h1;
                end
            end
            default: begin
                // A released SCL held low by the far side stretches the count
                if (cnt != '0) begin
                    if (!scl_oe_n || scl_sync) begin
                        next_cnt = cnt - CNT_W'(1);
                    end
                end else if (step == last_step) begin
                    next_st = eng_idle;
                    next_done = 1'h1;
                end else begin
                    if (step == 2'h1 && cmd_r == cmd_bit) begin
                        next_rx = sda_sync;
                    end
                    next_step = 2'(step + 2'h1);
                    plan = step_plan(cmd_r, next_step, tx_r, ~sda_oe_n, ~scl_oe_n);
                    load = 1'h1;
                end
            end
        endcase
        if (load) begin
            // Open drain: pins are only ever pulled low or released
            next_sda_oe_n = ~plan[3];
            next_scl_oe_n = ~plan[2];
            case (plan[1:0])
                2'h0: next_cnt = hs ? CNT_W'(LOW_HS_CYC) : CNT_W'(LOW_FAST_CYC);
                2'h1: next_cnt = hs ? CNT_W'(HIGH_HS_CYC) : CNT_W'(HIGH_FAST_CYC);
                default: next_cnt = CNT_W'(1);
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st <= eng_idle;
            cmd_r <= cmd_bit;
            step <= 2'h0;
            cnt <= '0;
            tx_r <= 1'h1;
            done <= 1'h0;
            rx_bit <= 1'h1;
            scl_oe_n <= 1'h1;
            sda_oe_n <= 1'h1;
        end else begin
            st <= next_st;
            cmd_r <= next_cmd;
            step <= next_step;
            cnt <= next_cnt;
            tx_r <= next_tx;
            done <= next_done;
            rx_bit <= next_rx;
            scl_oe_n <= next_scl_oe_n;
            sda_oe_n <= next_sda_oe_n;
        end
    end

    // Helper: length of the current stretch of SCL pulled low by the host
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_run <= 10'h000;
        end else begin
            low_run <= scl_oe_n ? 10'h000 : 10'(low_run + 10'h001);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_start_cond: assert property ($fell(sda_oe_n) && scl_oe_n |-> cmd_r == cmd_start)
        else $error("SDA pulled low under high SCL outside a START");
    a_stop_cond: assert property ($rose(sda_oe_n) && scl_oe_n |-> cmd_r == cmd_stop)
        else $error("SDA released under high SCL outside a STOP");
    a_scl_low_bound: assert property (low_run < 10'd1000)
        else $error("SCL held low far too long");
    a_ack_drive_low: assert property (st == eng_run && cmd_r == cmd_bit && step == 2'h1 && !tx_r
        |-> !sda_oe_n)
        else $error("Host ack not held low during SCL high");
endmodule

// [hdl/twi_host_ctrl.sv]
// Two-wire host controller for a sensor slave: reads, writes, alert response, general call, Hs
`timescale 1ns/100ps
// Functional notes
// - Host sends alert response byte 00011001
// - Host sends Hs master code first
// - Repeated START and address follow master code
// - Host keeps SCL at or above 1kHz
// - Both lines high means bus idle
// - SDA falling under high SCL is START
// - SDA rising under high SCL is STOP
// - Host sets byte count; receiver acks each
// - Acker holds SDA low through clock high
// - Host nacks last byte read from device
module twi_host_ctrl
    import twi_host_pkg::*;
#(
    parameter logic [2:0] HS_CODE_ID = 3'h0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic req_valid,
    input wire req_type req,
    output logic req_ready,
    output logic resp_valid,
    output resp_type resp,
    input wire logic alert_n_pin,
    output logic alert_pending,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n
);
    typedef enum {m_idle, m_start, m_code, m_rstart, m_addr, m_ptr, m_wr, m_rd, m_cmd,
                  m_stop} main_state_type;

    main_state_type state, next_state;
    req_type req_r, next_req;
    logic wait_eng, next_wait;
    logic [3:0] bitn, next_bitn;
    logic [7:0] shreg, next_shreg;
    logic [1:0] remain, next_remain;
    logic [15:0] rdata, next_rdata;
    logic nack, next_nack, hs_mode, next_hs, next_ready, next_resp_valid;
    resp_type next_resp;
    logic issue, eng_done, eng_rx, eng_tx, read_byte;
    eng_cmd_type eng_cmd;
    logic [7:0] addr_byte;
    logic alert_meta, alert_sync, pin_level;

    twi_bit_engine u_engine (
        .clk(clk),
        .resetn(resetn),
        .cmd_valid(issue),
        .cmd(eng_cmd),
        .tx_bit(eng_tx),
        .hs(hs_mode),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .done(eng_done),
        .rx_bit(eng_rx),
        .scl_oe_n(scl_oe_n),
        .sda_oe_n(sda_oe_n)
    );

    // Alert line is active low and shared; the user answers it with an alert op
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alert_meta <= 1'h1;
            alert_sync <= 1'h1;
            alert_pending <= 1'h0;
            pin_level <= 1'h0;
        end else begin
            alert_meta <= alert_n_pin;
            alert_sync <= alert_meta;
            alert_pending <= ~alert_sync;
            pin_level <= 1'h0;
        end
    end

    assign scl_out = pin_level;
    assign sda_out = pin_level;

    always_comb begin
        if (req_r.op == op_alert) begin
            addr_byte = ALERT_RESP_BYTE;
        end else if (req_r.op == op_gcall_latch || req_r.op == op_gcall_reset) begin
            addr_byte = GCALL_WRITE_BYTE;
        end else begin
            addr_byte = {DEV_ADDR_BASE, req_r.addr_pins, req_r.op == op_read};
        end
    end

    assign issue = (state != m_idle) && !wait_eng;
    assign read_byte = (state == m_rd);

    always_comb begin
        if (state == m_start || state == m_rstart) begin
            eng_cmd = cmd_start;
        end else if (state == m_stop) begin
            eng_cmd = cmd_stop;
        end else begin
            eng_cmd = cmd_bit;
        end
        if (bitn != 4'h8) begin
            eng_tx = read_byte ? 1'h1 : shreg[7];
        end else begin
            // Ack slot: release for the slave's ack, or nack our last read byte
            eng_tx = read_byte ? (remain == 2'h1) : 1'h1;
        end
    end

    always_comb begin
        next_state = state;
        next_req = req_r;
        next_wait = wait_eng;
        next_bitn = bitn;
        next_shreg = shreg;
        next_remain = remain;
        next_rdata = rdata;
        next_nack = nack;
        next_hs = hs_mode;
        next_ready = req_ready;
        next_resp_valid = 1'h0;
        next_resp = resp;
        if (issue) begin
            next_wait = 1'h1;
        end
        case (state)
            m_idle: begin
                if (req_valid && req_ready) begin
                    next_req = req;
                    next_state = m_start;
                    next_ready = 1'h0;
                    next_rdata = 16'h0000;
                    next_nack = 1'h0;
                    next_bitn = 4'h0;
                    if (req.op == op_alert || (req.op == op_read && req.nbytes == 2'h0)) begin
                        next_remain = 2'h1;
                    end else begin
                        next_remain = req.nbytes;
                    end
                end
            end
            default: begin
                if (eng_done) begin
                    next_wait = 1'h0;
                    if (state == m_start || state == m_rstart) begin
                        next_bitn = 4'h0;
                        if (state == m_start && req_r.hs) begin
                            next_state = m_code;
                            next_shreg = {HS_CODE_PREFIX, HS_CODE_ID};
                        end else begin
                            next_state = m_addr;
                            next_shreg = addr_byte;
                        end
                    end else if (state == m_stop) begin
                        next_state = m_idle;
                        next_hs = 1'h0;
                        next_ready = 1'h1;
                        next_resp_valid = 1'h1;
                        next_resp = '{rdata: rdata, nack: nack, alert_addr: rdata[7:1],
                                      alert_flag: rdata[0]};
                    end else if (bitn != 4'h8) begin
                        next_shreg = {shreg[6:0], eng_rx};
                        next_bitn = 4'(bitn + 4'h1);
                    end else begin
                        next_bitn = 4'h0;
                        case (state)
                            m_code: begin
                                // No ack is expected; speed switches before the restart
                                next_state = m_rstart;
                                next_hs = 1'h1;
                            end
                            m_addr: begin
                                if (eng_rx) begin
                                    next_nack = 1'h1;
                                    next_state = m_stop;
                                end else if (req_r.op == op_write) begin
                                    next_state = m_ptr;
                                    next_shreg = req_r.pointer;
                                end else if (req_r.op == op_read || req_r.op == op_alert) begin
                                    next_state = m_rd;
                                end else begin
                                    next_state = m_cmd;
                                    next_shreg = (req_r.op == op_gcall_reset) ?
                                                 GCALL_RESET_CMD : GCALL_LATCH_CMD;
                                end
                            end
                            m_ptr: begin
                                next_nack = eng_rx;
                                if (eng_rx || remain == 2'h0) begin
                                    next_state = m_stop;
                                end else begin
                                    next_state = m_wr;
                                    next_shreg = req_r.wdata[15:8];
                                end
                            end
                            m_wr: begin
                                next_nack = eng_rx;
                                next_remain = 2'(remain - 2'h1);
                                if (eng_rx || remain == 2'h1) begin
                                    next_state = m_stop;
                                end else begin
                                    next_shreg = req_r.wdata[7:0];
                                end
                            end
                            m_rd: begin
                                next_rdata = {rdata[7:0], shreg};
                                next_remain = 2'(remain - 2'h1);
                                if (remain == 2'h1) begin
                                    next_state = m_stop;
                                end
                            end
                            default: begin
                                next_nack = eng_rx;
                                next_state = m_stop;
                            end
                        endcase
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= m_idle;
            req_r <= '0;
            wait_eng <= 1'h0;
            bitn <= 4'h0;
            shreg <= 8'h00;
            remain <= 2'h0;
            rdata <= 16'h0000;
            nack <= 1'h0;
            hs_mode <= 1'h0;
            req_ready <= 1'h1;
            resp_valid <= 1'h0;
            resp <= '0;
        end else begin
            state <= next_state;
            req_r <= next_req;
            wait_eng <= next_wait;
            bitn <= next_bitn;
            shreg <= next_shreg;
            remain <= next_remain;
            rdata <= next_rdata;
            nack <= next_nack;
            hs_mode <= next_hs;
            req_ready <= next_ready;
            resp_valid <= next_resp_valid;
            resp <= next_resp;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_ara_byte: assert property (state == m_addr && bitn == 4'h0 && req_r.op == op_alert
        |-> shreg == ALERT_RESP_BYTE)
        else $error("Alert response address byte is wrong");
    a_hs_code_first: assert property (state == m_code && $past(state) != m_code
        |-> shreg[7:3] == HS_CODE_PREFIX && !hs_mode && $past(state) == m_start)
        else $error("Master code not first byte after START");
    a_rstart_follows: assert property (state == m_code ##1 state != m_code
        |-> state == m_rstart && hs_mode)
        else $error("Master code not followed by repeated START");
    a_hs_until_stop: assert property ($fell(hs_mode) |-> $past(state) == m_stop)
        else $error("Hs mode left without a STOP");
    a_read_nack_last: assert property (issue && state == m_rd && bitn == 4'h8
        |-> eng_tx == (remain == 2'h1))
        else $error("Read ack slot carries wrong ack");
    a_ack_release: assert property (issue && state != m_rd && eng_cmd == cmd_bit
        && bitn == 4'h8 |-> eng_tx)
        else $error("SDA not released for slave ack");
    a_idle_bus: assert property (state == m_idle |-> scl_oe_n && sda_oe_n)
        else $error("Bus not released while idle");
    a_resp_after_stop: assert property (resp_valid |-> $past(state) == m_stop
        && state == m_idle && req_ready)
        else $error("Answer given without closing STOP");

    c_alert_done: cover property (resp_valid && req_r.op == op_alert && !resp.nack);
    c_hs_read: cover property (resp_valid && req_r.hs && req_r.op == op_read);
    c_gcall_reset: cover property (resp_valid && req_r.op == op_gcall_reset);
    c_addr_nack: cover property (resp_valid && resp.nack);
endmodule

// [sim/twi_sensor_model.sv]
// Behavioural sensor slave on the two-wire bus, far side of the host controller
`timescale 1ns/100ps
module twi_sensor_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic [2:0] pins,
    input wire logic trip,
    input wire logic trip_high,
    output logic sda_low,
    output logic alert_n,
    output logic hs
);
    logic [15:0] regs [4] = '{default: 16'h0};
    logic [2:0] addr = 3'h0;
    logic [7:0] b;
    logic [7:0] c;
    logic [1:0] ptr = 2'h0;
    logic cause = 1'b0;
    logic again = 1'b0;
    logic acked;
    logic won;
    initial sda_low = 1'b0;
    initial alert_n = 1'b1;
    initial hs = 1'b0;
    always @(posedge trip) begin
        alert_n = 1'b0;
        cause = trip_high;
    end
    task automatic get(output logic [7:0] d);
        for (int i = 7; i >= 0; i--) @(posedge scl) d[i] = sda;
    endtask
    task automatic ack();
        @(negedge scl) sda_low = 1'b1;
        @(negedge scl) sda_low = 1'b0;
    endtask
    // Only ever pulls low; a lost bit releases the line for the rest of the byte
    task automatic send(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            sda_low = won & !d[i];
            @(posedge scl);
            if (d[i] && !sda) won = 1'b0;
            @(negedge scl);
        end
        sda_low = 1'b0;
        @(posedge scl) acked = !sda;
        @(negedge scl);
    endtask
    task automatic run();
        won = 1'b1;
        get(b);
        if (b == 8'h19 && !alert_n) begin
            ack();
            send({4'h9, addr, cause});
            if (won) alert_n = 1'b1;
        end else if (b == 8'h00) begin
            ack();
            get(c);
            ack();
            if (c == 8'h04 || c == 8'h06) addr = pins;
            if (c == 8'h06) begin
                regs = '{default: 16'h0};
                ptr = 2'h0;
                alert_n = 1'b1;
            end
        end else if (b[7:3] == 5'h01) begin
            hs = 1'b1;
        end else if (b[7:1] == {4'h9, addr}) begin
            ack();
            if (b[0]) begin
                alert_n = 1'b1;
                do begin
                    send(regs[ptr][15:8]);
                    if (acked) send(regs[ptr][7:0]);
                end while (acked);
            end else begin
                get(b);
                ack();
                ptr = b[1:0];
                forever begin
                    get(c);
                    ack();
                    regs[ptr][15:8] = c;
                    get(c);
                    ack();
                    regs[ptr][7:0] = c;
                end
            end
        end
    endtask
    initial forever begin
        if (!again) @(negedge sda iff scl === 1'b1);
        fork : xfer
            begin
                run();
                wait (1'b0);
            end
            @(posedge sda iff scl === 1'b1);
            @(negedge sda iff scl === 1'b1);
        join_any
        disable xfer;
        again = !sda;
        sda_low = 1'b0;
        if (sda) hs = 1'b0;
    end
endmodule

// [sim/two_wire_slave_alert_gcall_hs_tb_top.sv]
// Self-checking bench: host controller against the behavioural sensor slave
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module two_wire_slave_alert_gcall_hs_tb_top;
    import twi_host_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic req_valid = 1'b0;
    req_type req = '0;
    logic req_ready, resp_valid, alert_pending, scl_oe_n, sda_oe_n, sda_low, alert_n, hs;
    resp_type resp;
    logic [2:0] pins = 3'h0;
    logic trip = 1'b0;
    logic trip_high = 1'b0;
    logic hs_hit = 1'b0;
    logic [31:0] seed = 32'hffedd9b0;
    logic [15:0] ref_reg [4] = '{default: 16'h0};
    int err_count = 0;
    int compares = 0;
    // Open-drain wires with pull-ups; the slave never stretches the clock
    wire scl = scl_oe_n;
    wire sda = sda_oe_n & !sda_low;
    always #4 clk = ~clk;
    always @(posedge hs) hs_hit = 1'b1;
    twi_host_ctrl dut (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp), .alert_n_pin(alert_n),
        .alert_pending(alert_pending), .scl_in(scl), .scl_out(), .scl_oe_n(scl_oe_n),
        .sda_in(sda), .sda_out(), .sda_oe_n(sda_oe_n));
    twi_sensor_model slave (.scl(scl), .sda(sda), .pins(pins), .trip(trip),
        .trip_high(trip_high), .sda_low(sda_low), .alert_n(alert_n), .hs(hs));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic op(input op_type o, input logic h, input logic [2:0] p,
        input logic [7:0] ptr, input logic [15:0] w, input logic [1:0] n);
        int k = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{o, h, p, ptr, w, n};
        @(posedge clk);
        req_valid <= 1'b0;
        while (resp_valid !== 1'b1 && k < 30000) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k == 30000) err_count++;
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        seed = lfsr(seed);
        ref_reg[1] = seed[15:0];
        op(op_write, 1'b1, 3'h0, 8'h01, ref_reg[1], 2'd2);
        `CHK("write nack", 1'b0, resp.nack)
        op(op_read, 1'b1, 3'h0, 8'h00, 16'h0, 2'd2);
        `CHK("read data", ref_reg[1], resp.rdata)
        `CHK("hs seen", 1'b1, hs_hit)
        `CHK("hs after stop", 1'b0, hs)
        $display("test read_write done");
        op(op_read, 1'b1, 3'h5, 8'h00, 16'h0, 2'd1);
        `CHK("wrong addr nack", 1'b1, resp.nack)
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            trip_high <= i[0];
            trip <= 1'b1;
            repeat (8) @(posedge clk);
            trip <= 1'b0;
            `CHK("alert seen", 1'b1, alert_pending)
            op(op_alert, 1'b0, 3'h0, 8'h00, 16'h0, 2'd0);
            `CHK("alert addr", {DEV_ADDR_BASE, 3'h0}, resp.alert_addr)
            `CHK("alert flag", i[0], resp.alert_flag)
            repeat (6) @(posedge clk);
            `CHK("alert cleared", 1'b0, alert_pending)
        end
        op(op_alert, 1'b1, 3'h0, 8'h00, 16'h0, 2'd0);
        `CHK("idle alert nack", 1'b1, resp.nack)
        $display("test alert done");
        pins <= 3'h6;
        op(op_gcall_latch, 1'b1, 3'h0, 8'h00, 16'h0, 2'd0);
        `CHK("gcall nack", 1'b0, resp.nack)
        op(op_read, 1'b1, 3'h6, 8'h00, 16'h0, 2'd2);
        `CHK("latched read", ref_reg[1], resp.rdata)
        trip <= 1'b1;
        op(op_gcall_reset, 1'b1, 3'h6, 8'h00, 16'h0, 2'd0);
        trip <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK("reset alert", 1'b0, alert_pending)
        ref_reg = '{default: 16'h0};
        op(op_write, 1'b1, 3'h6, 8'h01, 16'h0, 2'd0);
        op(op_read, 1'b1, 3'h6, 8'h00, 16'h0, 2'd2);
        `CHK("reset data", ref_reg[1], resp.rdata)
        $display("test general_call done");
        end_sim;
    end
    initial begin
        // Nine Hs ops and two fast alert ops take about 55000 cycles
        repeat (90000) @(posedge clk);
        err_count++;
        end_sim;
    end
endmodule
